// ==== hw/tsa_alarm_iface.sv ====
// Conversion sequencer, alarm pins, serial timeout and address acknowledge.
// Assumes sclk is the serial clock pin; sdaIn and pins are asynchronous.
module tsa_alarm_iface
  import tsa_pkg::*;
#(
  parameter int unsigned CONV_CYCLES    = CONV_CYC,
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int unsigned PERIOD_CYCLES  = RATE_PERIOD_CYC
) (
  // System clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Serial link
  input  wire logic        sclk,
  input  wire logic        sdaIn,
  output logic             sdaOe,
  // Pins
  input  wire logic        standbyPinN,
  input  wire logic [1:0]  addrStrap,
  output logic             alertOe,
  output logic             overtempFirstOe,
  output logic             overtempSecondOe,
  // Control side
  input  wire logic [3:0]  rateCode,
  input  wire logic        runEnable,
  input  wire logic        oneShot,
  input  wire logic        statusRead,
  input  wire tsa_limits_t limits,
  input  wire tsa_temps_t  adcTemps,
  // Status side
  output tsa_temps_t       results,
  output logic             resultsExt,
  output logic             busy
);

  // --------------------------------------------------------------------
  // Pin synchronisers and strap capture
  // --------------------------------------------------------------------
  logic [2:0] syncA_reg;
  logic [2:0] syncB_reg;
  logic       sdaPrev_reg;
  logic       sclS;
  logic       sdaS;
  logic       stbyS;
  logic [1:0] strap_reg;
  logic       strapDone_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      syncA_reg     <= SYNC_RST;
      syncB_reg     <= SYNC_RST;
      sdaPrev_reg   <= 1'b1;
      strap_reg     <= STRAP_GND;
      strapDone_reg <= 1'b0;
    end else begin
      syncA_reg     <= {sclk, sdaIn, standbyPinN};
      syncB_reg     <= syncA_reg;
      sdaPrev_reg   <= syncB_reg[1];
      strapDone_reg <= 1'b1;
      if (!strapDone_reg) begin
        strap_reg <= addrStrap;
      end
    end
  end

  assign sclS  = syncB_reg[2];
  assign sdaS  = syncB_reg[1];
  assign stbyS = syncB_reg[0];

  // --------------------------------------------------------------------
  // Timeout counters and frame tracking
  // --------------------------------------------------------------------
  logic [31:0] lowCnt_reg  [2];
  logic [31:0] lowCnt_next [2];
  logic [1:0]  lowHit;
  logic [1:0]  lineLow;

  assign lineLow = {~sclS, ~sdaS};

  for (genvar i = 0; i < 2; i++) begin : g_tmo
    always_comb begin
      lowCnt_next[i] = 32'h0;
      if (lineLow[i] && !lowHit[i]) begin
        lowCnt_next[i] = lowCnt_reg[i] + 32'h1;
      end else if (lineLow[i]) begin
        lowCnt_next[i] = lowCnt_reg[i];
      end
    end
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        lowCnt_reg[i] <= 32'h0;
      end else begin
        lowCnt_reg[i] <= lowCnt_next[i];
      end
    end
    assign lowHit[i] = (lowCnt_reg[i] >= TIMEOUT_CYCLES - 1);
  end

  logic frameIdle_reg;
  logic frameIdle_next;
  logic restart_reg;
  logic restart_next;
  logic startCond;
  logic stopCond;
  logic timeout;

  assign startCond = sclS && sdaPrev_reg && !sdaS;
  assign stopCond  = sclS && !sdaPrev_reg && sdaS;
  assign timeout   = |lowHit;

  always_comb begin
    frameIdle_next = frameIdle_reg;
    restart_next   = 1'b0;
    if (timeout || stopCond) begin
      frameIdle_next = 1'b1;
    end else if (startCond && !frameIdle_reg) begin
      frameIdle_next = 1'b1;
      restart_next   = 1'b1;
    end else if (startCond || restart_reg) begin
      frameIdle_next = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frameIdle_reg <= 1'b1;
      restart_reg   <= 1'b0;
    end else begin
      frameIdle_reg <= frameIdle_next;
      restart_reg   <= restart_next;
    end
  end

  // Link logic is held in reset between frames and after a timeout
  logic linkRstN;
  assign linkRstN = nrst & ~frameIdle_reg;

  // --------------------------------------------------------------------
  // Link domain: address byte and acknowledge
  // --------------------------------------------------------------------
  logic [7:0] shift_reg;
  logic [3:0] bitCnt_reg;
  logic       ackSlot_reg;
  logic       araTgl_reg;
  logic [1:0] addrS1_reg;
  logic [1:0] addrS2_reg;
  logic [7:0] byteIn;
  logic [6:0] ownAddr;

  assign byteIn = {shift_reg[6:0], sdaIn};

  always_comb begin
    case (addrS2_reg)
      STRAP_VCC: ownAddr = ADDR_VCC;
      STRAP_OPEN: ownAddr = ADDR_OPEN;
      default: ownAddr = ADDR_GND;
    endcase
  end

  always_ff @(posedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      shift_reg   <= 8'h00;
      bitCnt_reg  <= 4'h0;
      ackSlot_reg <= 1'b0;
      addrS1_reg  <= STRAP_GND;
      addrS2_reg  <= STRAP_GND;
    end else begin
      addrS1_reg  <= strap_reg;
      addrS2_reg  <= addrS1_reg;
      ackSlot_reg <= 1'b0;
      if (bitCnt_reg < BITS_ACK) begin
        shift_reg  <= byteIn;
        bitCnt_reg <= bitCnt_reg + 4'h1;
      end else if (bitCnt_reg == BITS_ACK) begin
        bitCnt_reg <= bitCnt_reg + 4'h1;
      end
      if (bitCnt_reg == BITS_LAST) begin
        ackSlot_reg <= (byteIn[7:1] == ownAddr) ||
                       (byteIn[7:1] == ARA_ADDR && byteIn[0]);
      end
    end
  end

  // Alert response success toggles; survives the frame reset
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      araTgl_reg <= 1'b0;
    end else if (linkRstN && bitCnt_reg == BITS_LAST &&
                 byteIn == {ARA_ADDR, 1'b1}) begin
      araTgl_reg <= ~araTgl_reg;
    end
  end

  always_ff @(negedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      sdaOe <= 1'b0;
    end else begin
      sdaOe <= ackSlot_reg;
    end
  end

  logic [2:0] araSync_reg;
  logic       araEvent;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      araSync_reg <= 3'h0;
    end else begin
      araSync_reg <= {araSync_reg[1:0], araTgl_reg};
    end
  end

  assign araEvent = araSync_reg[2] ^ araSync_reg[1];

  // --------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------
  tsa_conv_state_t state_reg;
  tsa_conv_state_t state_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic [31:0] per_reg;
  logic [31:0] per_next;
  logic        pend_reg;
  logic        pend_next;
  logic        ext_reg;
  logic        ext_next;
  logic        shot_reg;
  logic        shot_next;
  logic        done_reg;
  logic        done_next;
  logic        busy_next;
  logic        resExt_next;
  tsa_temps_t  res_next;
  logic [31:0] convLen;
  logic [31:0] period;
  logic [3:0]  rateC;
  logic        slowRate;

  assign rateC    = (rateCode > RATE_MAX) ? RATE_MAX : rateCode;
  assign slowRate = (rateC <= RATE_EXT_MAX);
  assign period   = PERIOD_CYCLES >> rateC;
  assign convLen  = ext_reg ? (CONV_CYCLES << 1) : CONV_CYCLES;

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    per_next    = 32'h0;
    pend_next   = pend_reg;
    ext_next    = ext_reg;
    shot_next   = shot_reg;
    done_next   = 1'b0;
    res_next    = results;
    resExt_next = resultsExt;
    if (runEnable && stbyS) begin
      per_next = per_reg + 32'h1;
      if (per_reg >= period - 1) begin
        per_next  = 32'h0;
        pend_next = 1'b1;
      end
    end else begin
      pend_next = 1'b0;
    end
    case (state_reg)
      CONV_IDLE: begin
        if (oneShot || (pend_reg && stbyS)) begin
          state_next = CONV_RUN;
          cnt_next   = 32'h0;
          pend_next  = 1'b0;
          shot_next  = oneShot;
          ext_next   = oneShot || slowRate;
        end
      end
      CONV_RUN: begin
        cnt_next = cnt_reg + 32'h1;
        if (!stbyS && !shot_reg) begin
          state_next = CONV_IDLE;
        end else if (cnt_reg >= convLen - 1) begin
          state_next  = CONV_IDLE;
          done_next   = 1'b1;
          res_next    = adcTemps;
          resExt_next = ext_reg;
          if (!ext_reg) begin
            res_next.localT[LEGACY_LSBS-1:0]  = '0;
            res_next.remoteT[LEGACY_LSBS-1:0] = '0;
          end
        end
      end
      default: state_next = CONV_IDLE;
    endcase
    busy_next = (state_next == CONV_RUN);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= CONV_IDLE;
      cnt_reg    <= 32'h0;
      per_reg    <= 32'h0;
      pend_reg   <= 1'b0;
      ext_reg    <= 1'b0;
      shot_reg   <= 1'b0;
      done_reg   <= 1'b0;
      busy       <= 1'b0;
      results    <= '0;
      resultsExt <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      per_reg    <= per_next;
      pend_reg   <= pend_next;
      ext_reg    <= ext_next;
      shot_reg   <= shot_next;
      done_reg   <= done_next;
      busy       <= busy_next;
      results    <= res_next;
      resultsExt <= resExt_next;
    end
  end

  // --------------------------------------------------------------------
  // Alarm outputs
  // --------------------------------------------------------------------
  logic otFirst_next;
  logic otSecond_next;
  logic alert_next;
  logic beyond;
  logic alertClr;

  assign beyond = (results.localT > limits.highLim) ||
                  (results.remoteT > limits.highLim) ||
                  (results.localT < limits.lowLim) ||
                  (results.remoteT < limits.lowLim);
  assign alertClr = statusRead || araEvent;

  always_comb begin
    otFirst_next  = (results.localT > limits.otFirst) ||
                    (results.remoteT > limits.otFirst);
    otSecond_next = (results.localT > limits.otSecond) ||
                    (results.remoteT > limits.otSecond);
    alert_next    = (done_reg && beyond) ||
                    (alertOe && !alertClr);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      overtempFirstOe  <= 1'b0;
      overtempSecondOe <= 1'b0;
      alertOe          <= 1'b0;
    end else begin
      overtempFirstOe  <= otFirst_next;
      overtempSecondOe <= otSecond_next;
      alertOe          <= alert_next;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  logic [31:0] hlpCnt_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hlpCnt_reg <= 32'h0;
    end else begin
      hlpCnt_reg <= busy ? hlpCnt_reg + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence sAlarmEvent;
    done_reg && beyond;
  endsequence

  sequence sAlertHeld;
    alertOe && !alertClr;
  endsequence

  a_conv_length: assert property (
    done_reg |-> hlpCnt_reg == (resultsExt ? 2 * CONV_CYCLES : CONV_CYCLES))
    else $error("conversion length wrong");
  a_results_hold: assert property (
    busy && $past(busy) |-> $stable(results))
    else $error("results changed during conversion");
  a_both_chan: assert property (
    $rose(done_reg) && resultsExt |->
      results == $past(adcTemps, 1))
    else $error("channel result not captured");
  a_legacy_res: assert property (
    !resultsExt |-> results.localT[2:0] == 3'h0 &&
                    results.remoteT[2:0] == 3'h0)
    else $error("legacy result has fraction bits");
  a_overtemp_pin: assert property (
    ##1 overtempFirstOe == $past(results.localT > limits.otFirst ||
                                 results.remoteT > limits.otFirst))
    else $error("overtemp pin disagrees with threshold");
  a_alert_set: assert property (
    sAlarmEvent |=> alertOe)
    else $error("alert not raised");
  a_alert_latch: assert property (
    sAlertHeld |=> alertOe)
    else $error("alert dropped without acknowledge");
  a_timeout_rst: assert property (
    timeout |=> frameIdle_reg)
    else $error("timeout did not reset serial interface");
  a_standby_hold: assert property (
    !stbyS && !busy && !oneShot |=> !busy ##0 $stable(results))
    else $error("activity during standby");

endmodule

// ==== hw/tsa_pkg.sv ====
// Constants and types of the temperature sensor alarm interface.
// Assumes a 25 MHz system clock; analog front end supplies ADC words.
package tsa_pkg;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_KHZ         = 25_000;
  localparam int unsigned CONV_TIME_MS    = 125;
  localparam int unsigned CONV_CYC        = CONV_TIME_MS * CLK_KHZ;
  localparam int unsigned TIMEOUT_MS      = 37;
  localparam int unsigned TIMEOUT_CYC     = TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned RATE_PERIOD_MS  = 16_000;
  localparam int unsigned RATE_PERIOD_CYC = RATE_PERIOD_MS * CLK_KHZ;

  // --------------------------------------------------------------------
  // Rate codes, data layout, addresses
  // --------------------------------------------------------------------
  localparam logic [3:0] RATE_EXT_MAX = 4'h6;
  localparam logic [3:0] RATE_MAX     = 4'h8;
  localparam int         TEMP_W       = 11;
  localparam int         LEGACY_LSBS  = 3;
  localparam logic [1:0] STRAP_GND    = 2'h0;
  localparam logic [1:0] STRAP_VCC    = 2'h1;
  localparam logic [1:0] STRAP_OPEN   = 2'h2;
  // Slave address values are arbitrary
  localparam logic [6:0] ADDR_GND     = 7'h2A;
  localparam logic [6:0] ADDR_VCC     = 7'h2B;
  localparam logic [6:0] ADDR_OPEN    = 7'h2C;
  localparam logic [6:0] ARA_ADDR     = 7'h0C;
  localparam logic [2:0] SYNC_RST     = 3'h7;
  localparam logic [3:0] BITS_LAST    = 4'h7;
  localparam logic [3:0] BITS_ACK     = 4'h8;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef struct packed {
    logic signed [TEMP_W-1:0] localT;
    logic signed [TEMP_W-1:0] remoteT;
  } tsa_temps_t;

  typedef struct packed {
    logic signed [TEMP_W-1:0] highLim;
    logic signed [TEMP_W-1:0] lowLim;
    logic signed [TEMP_W-1:0] otFirst;
    logic signed [TEMP_W-1:0] otSecond;
  } tsa_limits_t;

  typedef enum {CONV_IDLE, CONV_RUN} tsa_conv_state_t;

endpackage

// ==== tb/tsa_alarm_iface_test.sv ====
// Self-checking bench: conversions, alarms, standby, address, timeouts.
// Assumes tb/tsa_smbus_host.sv and shortened conversion and timeout counts.
module tsa_alarm_iface_test
  import tsa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(nm, exp, got) begin checkCount++; if ((got) !== (exp)) begin \
  mismatches++; \
  $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end

  localparam int CONV = 50;
  localparam int TMO  = 40;
  localparam int HALF = 126;

  logic        mclk, nrst, sclk, hostPull, sdaOe, standbyPinN;
  logic [1:0]  addrStrap;
  logic        alertOe, overtempFirstOe, overtempSecondOe;
  logic [3:0]  rateCode;
  logic        runEnable, oneShot, statusRead, resultsExt, busy, ack;
  tsa_limits_t limits;
  tsa_temps_t  adcTemps, results, saved;
  wire         sdaLine;
  int          mismatches, checkCount;

  assign sdaLine = ~(hostPull | sdaOe);

  tsa_alarm_iface #(
    .CONV_CYCLES    (CONV),
    .TIMEOUT_CYCLES (TMO),
    .PERIOD_CYCLES  (2048)
  ) u_tsa_alarm_iface (
    .mclk(mclk), .nrst(nrst), .sclk(sclk), .sdaIn(sdaLine), .sdaOe(sdaOe),
    .standbyPinN(standbyPinN), .addrStrap(addrStrap), .alertOe(alertOe),
    .overtempFirstOe(overtempFirstOe), .overtempSecondOe(overtempSecondOe),
    .rateCode(rateCode), .runEnable(runEnable), .oneShot(oneShot),
    .statusRead(statusRead), .limits(limits), .adcTemps(adcTemps),
    .results(results), .resultsExt(resultsExt), .busy(busy)
  );

  tsa_smbus_host #(.HALF_NS(HALF)) u_tsa_smbus_host (
    .sclk(sclk), .sdaPull(hostPull), .sdaLine(sdaLine)
  );

  always #20 mclk = ~mclk;

  // --------------------------------------------------------------------
  // Expectations and helpers
  // --------------------------------------------------------------------
  function automatic tsa_temps_t expRes(tsa_temps_t t, logic ext);
    expRes = t;
    if (!ext) begin
      expRes.localT[LEGACY_LSBS-1:0]  = '0;
      expRes.remoteT[LEGACY_LSBS-1:0] = '0;
    end
  endfunction

  function automatic logic over(tsa_temps_t r, logic signed [TEMP_W-1:0] t);
    return (r.localT > t) || (r.remoteT > t);
  endfunction

  function automatic tsa_temps_t rndTemps();
    rndTemps.localT  = TEMP_W'($urandom);
    rndTemps.remoteT = TEMP_W'($urandom);
  endfunction

  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic convCheck(int expLen, logic ext);
    tsa_temps_t prev;
    tsa_temps_t er;
    logic       expAlert;
    int         n;
    #1;
    prev = results;
    n = 0;
    while (busy !== 1'b1 && n < 4000) begin
      step(1);
      n++;
    end
    n = 0;
    while (busy === 1'b1 && n < 200) begin
      `CHK("heldResults", prev, results)
      step(1);
      n++;
    end
    er = expRes(adcTemps, ext);
    expAlert = over(er, limits.highLim) || (er.localT < limits.lowLim) ||
               (er.remoteT < limits.lowLim);
    `CHK("convLength", expLen, n)
    `CHK("results", er, results)
    `CHK("resultsExt", ext, resultsExt)
    step(2);
    `CHK("alert", expAlert, alertOe)
    `CHK("otFirst", over(er, limits.otFirst), overtempFirstOe)
    `CHK("otSecond", over(er, limits.otSecond), overtempSecondOe)
  endtask

  task automatic clearAlert();
    @(posedge mclk) statusRead <= 1'b1;
    @(posedge mclk) statusRead <= 1'b0;
    step(1);
    `CHK("alertCleared", 1'b0, alertOe)
  endtask

  task automatic oneShotConv(tsa_temps_t t);
    clearAlert();
    @(posedge mclk);
    adcTemps <= t;
    oneShot  <= 1'b1;
    @(posedge mclk) oneShot <= 1'b0;
    convCheck(2 * CONV, 1'b1);
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && checkCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    tally_and_finish();
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    standbyPinN = 1'b1;
    addrStrap = STRAP_GND;
    rateCode = 4'h8;
    runEnable = 1'b0;
    oneShot = 1'b0;
    statusRead = 1'b0;
    adcTemps = '0;
    limits = '{highLim: 11'sh190, lowLim: -11'sh190,
               otFirst: 11'shC8, otSecond: 11'sh258};
    mismatches = 0;
    checkCount = 0;
    void'($urandom(28));
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    step(2);
    `CHK("resetOuts", 5'h00,
      {alertOe, overtempFirstOe, overtempSecondOe, sdaOe, busy})
    oneShotConv('{localT: limits.highLim, remoteT: limits.lowLim});
    for (int i = 0; i < 5; i++) begin
      oneShotConv(rndTemps());
    end
    for (int c = 0; c <= 9; c++) begin
      @(posedge mclk);
      runEnable <= 1'b0;
      rateCode  <= (c > 8) ? 4'($urandom_range(15, 9)) : 4'(c);
      adcTemps  <= rndTemps();
      step(2 * CONV + 2);
      clearAlert();
      @(posedge mclk) runEnable <= 1'b1;
      convCheck((c <= 6) ? 2 * CONV : CONV, c <= 6);
    end
    for (int k = 0; k < 40 && busy !== 1'b1; k++) step(1);
    step(5);
    saved = results;
    @(posedge mclk) standbyPinN <= 1'b0;
    step(6);
    `CHK("standbyAbort", 1'b0, busy)
    step(3 * CONV);
    `CHK("standbyIdle", 1'b0, busy)
    `CHK("standbyKeep", saved, results)
    oneShotConv(rndTemps());
    @(posedge mclk) standbyPinN <= 1'b1;
    runEnable <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      @(posedge mclk) nrst <= 1'b0;
      addrStrap <= 2'(s);
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      step(3);
      for (int j = 0; j < 3; j++) begin
        u_tsa_smbus_host.startCond();
        u_tsa_smbus_host.sendByte({(j == 1) ? ADDR_VCC : (j == 2) ?
          ADDR_OPEN : ADDR_GND, 1'(j)}, 0, ack);
        u_tsa_smbus_host.stopCond();
        `CHK("addrAck", (j == s), ack)
      end
    end
    u_tsa_smbus_host.dataLow(TMO * 40 + 400);
    u_tsa_smbus_host.sendByte({ADDR_OPEN, 1'b0}, 0, ack);
    u_tsa_smbus_host.stopCond();
    `CHK("ackAfterDataLow", 1'b0, ack)
    u_tsa_smbus_host.startCond();
    fork
      u_tsa_smbus_host.sendByte({ADDR_OPEN, 1'b0}, TMO * 40 + 800, ack);
    join_none
    #(16 * HALF + 60);
    `CHK("ackHeld", 1'b1, sdaOe)
    #(TMO * 40 + 400);
    `CHK("ackReleased", 1'b0, sdaOe)
    wait fork;
    `CHK("lateAck", 1'b0, ack)
    u_tsa_smbus_host.stopCond();
    oneShotConv('{localT: 11'sh3FF, remoteT: 11'sh000});
    u_tsa_smbus_host.startCond();
    u_tsa_smbus_host.sendByte({ARA_ADDR, 1'b1}, 0, ack);
    u_tsa_smbus_host.stopCond();
    step(4);
    `CHK("araAck", 1'b1, ack)
    `CHK("araClear", 1'b0, alertOe)
    tally_and_finish();
  end
endmodule

// ==== tb/tsa_smbus_host.sv ====
// Behavioural host controller for the two-wire link of the alarm block.
// Assumes an open-drain data line with pull-up, resolved by the bench.
module tsa_smbus_host #(
  parameter int HALF_NS = 126
) (
  // Link pins
  output logic        sclk,
  output logic        sdaPull,
  input  wire logic   sdaLine
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock stands high and data is released between frames
  initial begin
    sclk    = 1'b1;
    sdaPull = 1'b0;
  end

  // --------------------------------------------------------------------
  // Frame tasks
  // --------------------------------------------------------------------
  // Data falls with clock high, held for ns before the clock drops
  task automatic dataLow(input int ns);
    sdaPull = 1'b1;
    #ns;
    sclk = 1'b0;
    #HALF_NS;
  endtask

  task automatic startCond();
    dataLow(2 * HALF_NS);
  endtask

  // Eight bits MSB first, then the acknowledge clock after stallNs
  task automatic sendByte(input logic [7:0] b, input int stallNs,
                          output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sdaPull = ~b[i];
      #HALF_NS;
      sclk = 1'b1;
      #HALF_NS;
      sclk = 1'b0;
    end
    sdaPull = 1'b0;
    #(HALF_NS + stallNs);
    sclk = 1'b1;
    ack = (sdaLine === 1'b0);
    #HALF_NS;
    sclk = 1'b0;
    #HALF_NS;
  endtask

  task automatic stopCond();
    sdaPull = 1'b1;
    #HALF_NS;
    sclk = 1'b1;
    #(2 * HALF_NS);
    sdaPull = 1'b0;
    #(2 * HALF_NS);
  endtask
endmodule
